// >>> cswi_pkg.sv
// constants, opcodes, register map and types for the processor core slice
package cswi_pkg;
   // register bus geometry
   localparam int AV_ADDR_W = 5;
   localparam int AV_DATA_W = 32;
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_PC = 5'h08;
   localparam logic [4:0] REG_STACK_INDEX = 5'h0C;
   localparam logic [4:0] REG_ACC_FLAGS = 5'h10;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_SOFT_IRQ = 1;
   localparam int STATUS_WAITING = 0;
   localparam int STATUS_FETCHING = 1;
   localparam int STATUS_IRQ_PEND = 2;
   // opcodes
   localparam logic [7:0] OPC_PREFIX = 8'h9E;
   localparam logic [7:0] OPC_SOFT_TRAP = 8'h83;
   localparam logic [7:0] OPC_ACC_TO_FLAGS = 8'h84;
   localparam logic [7:0] OPC_FLAGS_TO_ACC = 8'h85;
   localparam logic [7:0] OPC_WAIT = 8'h8F;
   localparam logic [7:0] OPC_INDEX_TO_STACK = 8'h94;
   localparam logic [7:0] OPC_STACK_TO_INDEX = 8'h95;
   localparam logic [7:0] OPC_ACC_TO_INDEX = 8'h97;
   localparam logic [7:0] OPC_INDEX_TO_ACC = 8'h9F;
   localparam logic [7:0] OPC_ZC_DIR = 8'h3D;
   localparam logic [7:0] OPC_ZC_ACC = 8'h4D;
   localparam logic [7:0] OPC_ZC_IDX = 8'h5D;
   localparam logic [7:0] OPC_ZC_IX1 = 8'h6D;
   localparam logic [7:0] OPC_ZC_IX = 8'h7D;
   localparam logic [7:0] OPC_MOV_DIXP = 8'h5E;
   localparam logic [7:0] OPC_MOV_IMD = 8'h6E;
   localparam logic [7:0] OPC_MOV_IXPD = 8'h7E;
   localparam logic [3:0] LOW_LOAD = 4'h6;
   // flag register layout and reset values
   localparam int CCR_V = 7;
   localparam int CCR_H = 4;
   localparam int CCR_I = 3;
   localparam int CCR_N = 2;
   localparam int CCR_Z = 1;
   localparam int CCR_C = 0;
   localparam logic [7:0] CCR_FIXED = 8'h60;
   localparam logic [7:0] CCR_RESET = 8'h68;
   localparam logic [15:0] SP_RESET = 16'h00FF;
   localparam logic [2:0] PUSH_LAST = 3'h4;
   typedef enum {
      ST_FETCH, ST_PRE, ST_ADR1, ST_ADR2, ST_READ, ST_DST, ST_WRITE,
      ST_XFER, ST_TRAP, ST_PUSH, ST_VECH, ST_VECL, ST_WAITING
   } cswi_state_type;
   typedef enum {
      M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_SP1, M_SP2,
      M_IMD, M_DIXP, M_IXPD, M_BRDIR
   } cswi_mode_type;
   typedef enum {OP_ZC, OP_LOAD, OP_MOV, OP_BR} cswi_op_type;
endpackage

// >>> cswi_core.sv
// core slice: trap entry, transfers, zero compare, wait, operand modes, avalon slave
// Operation
// [RQ1] trap opcode 83: 9 cycles, pc+1, push pc low, pc high, x, a, flags
// [RQ2] after stacking set interrupt mask, load pc from vector, other flags kept
// [RQ3] zero compare forms: clear v, update n and z, store nothing
// [RQ4] opcode 94, 2 cycles: stack pointer gets index pair minus one
// [RQ5] 95 gives sp plus one; 84/85/97/9f copy; only 84 alters flags
// [RQ6] wait opcode 8f issues in 1 cycle and clears the interrupt mask
// [RQ7] after wait the core holds its state until an interrupt arrives
// [RQ8] direct to indexed move: source direct, destination at index, index incremented
// [RQ9] indexed to direct move: source at index, index incremented, write direct
// [RQ10] post increment indexed: address is index, index incremented after access
// [RQ11] immediate to direct move writes the immediate byte to the direct address
// [RQ12] stack short mode: address is sp plus unsigned offset byte
// [RQ13] stack long mode: address is sp plus two-byte offset
// [RQ14] indexed long mode: high then low offset byte added to index
// [RQ15] extended mode: high then low byte form the full address
// [RQ16] indexed short mode: one offset byte added to index
// [RQ17] direct bit branch: address byte then relative offset applied when taken
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cswi_core
   import cswi_pkg::*;
#(
   parameter logic [15:0] RESET_PC = 16'h0100,
   parameter logic [15:0] TRAP_VECTOR = 16'hFFFC,
   parameter logic [15:0] IRQ_VECTOR = 16'hFFFA
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // avalon-mm register slave
   input wire logic [cswi_pkg::AV_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [cswi_pkg::AV_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [cswi_pkg::AV_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // program and data memory, asynchronous read
   output logic [15:0] mem_addr,
   output logic mem_read,
   output logic mem_write,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // external interrupt request, level
   input wire logic irq
);
   import cswi_pkg::*;

   cswi_state_type state_q;
   cswi_mode_type mode_q;
   cswi_op_type op_q;
   logic [15:0] pc_q, sp_q, hx_q, ea_q;
   logic [7:0] acc_q, ccr_q, b1_q, dat_q;
   logic [2:0] push_q;
   logic irq_entry_q, run_q, soft_irq_q, rd_done_q;
   logic irq_any, take_irq, fetch_go, soft_set;
   logic [7:0] op_byte;

   // flags after a byte test: v cleared, n and z from the value
   function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
      logic [7:0] r;
      r = f;
      r[CCR_V] = 1'b0;
      r[CCR_N] = v[7];
      r[CCR_Z] = (v == 8'h00);
      return r;
   endfunction

   // operand mode of a memory opcode, prefix selects the stack forms
   function automatic cswi_mode_type mode_of(input logic pre, input logic [7:0] o);
      if (pre) return (o[7:4] == 4'hD) ? M_SP2 : M_SP1;
      if (o == OPC_MOV_DIXP) return M_DIXP;
      if (o == OPC_MOV_IMD) return M_IMD;
      if (o == OPC_MOV_IXPD) return M_IXPD;
      case (o[7:4])
         4'h0: return M_BRDIR;
         4'hC: return M_EXT;
         4'hD: return M_IX2;
         4'h6, 4'hE: return M_IX1;
         4'h7, 4'hF: return M_IX;
         default: return M_DIR;
      endcase
   endfunction

   function automatic cswi_op_type op_of(input logic [7:0] o);
      if (o[7:4] == 4'h0) return OP_BR;
      if (o[3:0] == 4'hD) return OP_ZC;
      if (o[3:0] == 4'hE) return OP_MOV;
      return OP_LOAD;
   endfunction

   // bit branch opcodes: bit number in bits 3:1, bit 0 picks branch on clear
   function automatic logic [2:0] op_byte_bit(input logic [7:0] o);
      return o[3:1];
   endfunction

   function automatic logic op_byte_clr(input logic [7:0] o);
      return o[0];
   endfunction

   // memory opcodes that this slice executes; other opcodes go to the fetch decode, unknown ones run as no-ops
   function automatic logic is_mem_op(input logic pre, input logic [7:0] o);
      if (pre) return (o == OPC_ZC_IX1) || (o == {4'hD, LOW_LOAD}) || (o == {4'hE, LOW_LOAD});
      return (o[7:4] == 4'h0) || (o == OPC_ZC_DIR) || (o == OPC_ZC_IX1) || (o == OPC_ZC_IX)
         || (o == OPC_MOV_DIXP) || (o == OPC_MOV_IMD) || (o == OPC_MOV_IXPD)
         || ((o[3:0] == LOW_LOAD) && (o[7:4] >= 4'hB));
   endfunction

   assign irq_any = irq | soft_irq_q;
   assign take_irq = run_q && (state_q == ST_FETCH) && irq_any && !ccr_q[CCR_I];
   assign fetch_go = run_q && (state_q == ST_FETCH) && !take_irq;
   assign op_byte = mem_rdata;

   // memory request follows the sequencer state
   always_comb begin
      mem_addr = pc_q;
      mem_read = 1'b0;
      mem_write = 1'b0;
      mem_wdata = dat_q;
      unique case (state_q)
         ST_FETCH: mem_read = fetch_go;
         ST_PRE, ST_ADR1, ST_ADR2, ST_DST: mem_read = 1'b1;
         ST_READ: begin
            mem_addr = ea_q;
            mem_read = 1'b1;
         end
         ST_WRITE: begin
            mem_addr = ea_q;
            mem_write = 1'b1;
         end
         ST_PUSH: begin
            mem_addr = sp_q;
            mem_write = 1'b1; // [RQ1]
            unique case (push_q)
               3'h0: mem_wdata = pc_q[7:0];
               3'h1: mem_wdata = pc_q[15:8];
               3'h2: mem_wdata = hx_q[7:0];
               3'h3: mem_wdata = acc_q;
               default: mem_wdata = ccr_q;
            endcase
         end
         ST_VECH: begin
            mem_addr = irq_entry_q ? IRQ_VECTOR : TRAP_VECTOR; // [RQ2]
            mem_read = 1'b1;
         end
         ST_VECL: begin
            mem_addr = (irq_entry_q ? IRQ_VECTOR : TRAP_VECTOR) + 16'h0001;
            mem_read = 1'b1;
         end
         ST_XFER, ST_TRAP, ST_WAITING: mem_read = 1'b0;
      endcase
   end

   // sequencer and programmer registers
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= ST_FETCH;
         mode_q <= M_DIR;
         op_q <= OP_ZC;
         pc_q <= RESET_PC;
         sp_q <= SP_RESET;
         hx_q <= 16'h0000;
         ea_q <= 16'h0000;
         acc_q <= 8'h00;
         ccr_q <= CCR_RESET;
         b1_q <= 8'h00;
         dat_q <= 8'h00;
         push_q <= 3'h0;
         irq_entry_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_FETCH, ST_PRE: begin
               if (take_irq) begin
                  irq_entry_q <= 1'b1;
                  state_q <= ST_TRAP;
               end else if (state_q == ST_PRE || fetch_go) begin
                  pc_q <= pc_q + 16'h0001;
                  state_q <= ST_FETCH;
                  op_q <= op_of(op_byte);
                  mode_q <= mode_of(state_q == ST_PRE, op_byte);
                  if (state_q == ST_FETCH && op_byte == OPC_PREFIX) begin
                     state_q <= ST_PRE;
                  end else if (is_mem_op(state_q == ST_PRE, op_byte)) begin
                     // no-offset forms address through the index at once
                     if (state_q == ST_FETCH && (op_byte == OPC_ZC_IX ||
                         op_byte == OPC_MOV_IXPD || op_byte[7:4] == 4'hF)) begin
                        ea_q <= hx_q; // [RQ10]
                        state_q <= ST_READ;
                     end else begin
                        state_q <= ST_ADR1;
                     end
                  end else if (state_q == ST_FETCH) begin
                     unique case (op_byte)
                        OPC_SOFT_TRAP: begin
                           irq_entry_q <= 1'b0;
                           state_q <= ST_TRAP; // [RQ1]
                        end
                        OPC_WAIT: begin
                           ccr_q[CCR_I] <= 1'b0; // [RQ6]
                           state_q <= ST_WAITING;
                        end
                        OPC_ACC_TO_FLAGS, OPC_INDEX_TO_STACK, OPC_STACK_TO_INDEX:
                           state_q <= ST_XFER;
                        OPC_ZC_ACC: ccr_q <= nz_flags(ccr_q, acc_q); // [RQ3]
                        OPC_ZC_IDX: ccr_q <= nz_flags(ccr_q, hx_q[7:0]); // [RQ3]
                        OPC_ACC_TO_INDEX: hx_q[7:0] <= acc_q; // [RQ5]
                        OPC_INDEX_TO_ACC: acc_q <= hx_q[7:0]; // [RQ5]
                        OPC_FLAGS_TO_ACC: acc_q <= ccr_q; // [RQ5]
                        default: state_q <= ST_FETCH;
                     endcase
                  end
                  if (state_q == ST_FETCH) b1_q <= op_byte;
               end
            end
            ST_XFER: begin
               // second cycle of the two-cycle transfers
               unique case (b1_q)
                  OPC_INDEX_TO_STACK: sp_q <= hx_q - 16'h0001; // [RQ4]
                  OPC_STACK_TO_INDEX: hx_q <= sp_q + 16'h0001; // [RQ5]
                  default: ccr_q <= acc_q | CCR_FIXED; // [RQ5]
               endcase
               state_q <= ST_FETCH;
            end
            ST_ADR1: begin
               // a bit branch keeps its opcode in b1, the bit number is needed at the read
               if (mode_q != M_BRDIR) b1_q <= mem_rdata;
               pc_q <= pc_q + 16'h0001;
               state_q <= ST_READ;
               unique case (mode_q)
                  M_DIR, M_DIXP: ea_q <= {8'h00, mem_rdata}; // [RQ8]
                  M_IX1: ea_q <= hx_q + {8'h00, mem_rdata}; // [RQ16]
                  M_SP1: ea_q <= sp_q + {8'h00, mem_rdata}; // [RQ12]
                  M_BRDIR: begin
                     ea_q <= {8'h00, mem_rdata}; // [RQ17]
                     state_q <= ST_ADR2;
                  end
                  default: state_q <= ST_ADR2;
               endcase
            end
            ST_ADR2: begin
               pc_q <= pc_q + 16'h0001;
               state_q <= ST_READ;
               unique case (mode_q)
                  M_EXT: ea_q <= {b1_q, mem_rdata}; // [RQ15]
                  M_IX2: ea_q <= hx_q + {b1_q, mem_rdata}; // [RQ14]
                  M_SP2: ea_q <= sp_q + {b1_q, mem_rdata}; // [RQ13]
                  M_IMD: begin
                     dat_q <= b1_q; // [RQ11]
                     ea_q <= {8'h00, mem_rdata};
                     ccr_q <= nz_flags(ccr_q, b1_q);
                     state_q <= ST_WRITE;
                  end
                  default: begin
                     // bit branch: ea already holds the address, this byte the offset
                     dat_q <= mem_rdata; // [RQ17]
                  end
               endcase
            end
            ST_READ: begin
               state_q <= ST_FETCH;
               unique case (op_q)
                  OP_ZC: ccr_q <= nz_flags(ccr_q, mem_rdata); // [RQ3]
                  OP_LOAD: begin
                     acc_q <= mem_rdata;
                     ccr_q <= nz_flags(ccr_q, mem_rdata);
                  end
                  OP_BR: begin
                     // bit number sits in opcode bits 3:1, bit 0 picks clear
                     ccr_q[CCR_C] <= mem_rdata[op_byte_bit(b1_q)];
                     if (mem_rdata[op_byte_bit(b1_q)] != op_byte_clr(b1_q))
                        pc_q <= pc_q + {{8{dat_q[7]}}, dat_q}; // [RQ17]
                  end
                  OP_MOV: begin
                     dat_q <= mem_rdata;
                     ccr_q <= nz_flags(ccr_q, mem_rdata);
                     if (mode_q == M_DIXP) begin
                        ea_q <= hx_q; // [RQ8]
                        hx_q <= hx_q + 16'h0001; // [RQ8]
                        state_q <= ST_WRITE;
                     end else begin
                        hx_q <= hx_q + 16'h0001; // [RQ9] [RQ10]
                        state_q <= ST_DST;
                     end
                  end
               endcase
            end
            ST_DST: begin
               ea_q <= {8'h00, mem_rdata}; // [RQ9]
               pc_q <= pc_q + 16'h0001;
               state_q <= ST_WRITE;
            end
            ST_WRITE: state_q <= ST_FETCH;
            ST_TRAP: begin
               push_q <= 3'h0;
               state_q <= ST_PUSH;
            end
            ST_PUSH: begin
               sp_q <= sp_q - 16'h0001; // [RQ1]
               push_q <= push_q + 3'h1;
               if (push_q == PUSH_LAST) state_q <= ST_VECH;
            end
            ST_VECH: begin
               ccr_q[CCR_I] <= 1'b1; // [RQ2]
               pc_q[15:8] <= mem_rdata; // [RQ2]
               state_q <= ST_VECL;
            end
            ST_VECL: begin
               pc_q[7:0] <= mem_rdata; // [RQ2]
               state_q <= ST_FETCH;
            end
            ST_WAITING: begin
               // all state frozen; only an interrupt wakes the core
               if (irq_any) begin
                  irq_entry_q <= 1'b1;
                  state_q <= ST_TRAP; // [RQ7]
               end
            end
         endcase
      end
   end

   // software interrupt request: set from the bus wins over the entry clear
   assign soft_set = avs_write && (avs_address == REG_CTRL) && avs_byteenable[0]
      && avs_writedata[CTRL_SOFT_IRQ];
   always_ff @(posedge clock) begin
      if (reset) begin
         run_q <= 1'b0;
         soft_irq_q <= 1'b0;
      end else begin
         if (avs_write && avs_address == REG_CTRL && avs_byteenable[0])
            run_q <= avs_writedata[CTRL_RUN];
         if (soft_set)
            soft_irq_q <= 1'b1;
         else if (state_q == ST_TRAP && irq_entry_q)
            soft_irq_q <= 1'b0;
      end
   end

   // reads take one wait state so that read data come from a flip-flop
   assign avs_waitrequest = avs_read && !rd_done_q;
   always_ff @(posedge clock) begin
      if (reset) begin
         rd_done_q <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_done_q <= avs_read && !rd_done_q;
         if (avs_read && !rd_done_q) begin
            unique case (avs_address)
               REG_CTRL: avs_readdata <= {30'h0, soft_irq_q, run_q};
               REG_STATUS: avs_readdata <= {29'h0, irq_any,
                  state_q == ST_FETCH, state_q == ST_WAITING};
               REG_PC: avs_readdata <= {16'h0000, pc_q};
               REG_STACK_INDEX: avs_readdata <= {hx_q, sp_q};
               REG_ACC_FLAGS: avs_readdata <= {16'h0000, ccr_q, acc_q};
               default: avs_readdata <= 32'h0000_0000; // unmapped reads zero
            endcase
         end
      end
   end

   // trap entry length and mask
   trap_length_a: assert property (@(posedge clock) disable iff (reset) // [RQ1]
      (fetch_go && op_byte == OPC_SOFT_TRAP) |-> ##9 (state_q == ST_FETCH && ccr_q[CCR_I]
      && sp_q == $past(sp_q, 9) - 16'h0005))
      else $error("trap entry not 9 cycles");
   trap_flags_a: assert property (@(posedge clock) disable iff (reset) // [RQ2]
      (state_q == ST_VECH) |=> (ccr_q[CCR_N] == $past(ccr_q[CCR_N])) && ccr_q[CCR_I])
      else $error("trap entry disturbed flags");
   zc_flags_a: assert property (@(posedge clock) disable iff (reset) // [RQ3]
      (state_q == ST_READ && op_q == OP_ZC) |=> !ccr_q[CCR_V] && $stable(acc_q)
      && ccr_q[CCR_Z] == ($past(mem_rdata) == 8'h00))
      else $error("zero compare flags wrong");
   idx_stack_a: assert property (@(posedge clock) disable iff (reset) // [RQ4]
      (fetch_go && op_byte == OPC_INDEX_TO_STACK) |-> ##2
      (sp_q == $past(hx_q, 2) - 16'h0001 && $stable(ccr_q)))
      else $error("index to stack transfer wrong");
   stack_idx_a: assert property (@(posedge clock) disable iff (reset) // [RQ5]
      (fetch_go && op_byte == OPC_STACK_TO_INDEX) |-> ##2 (hx_q == $past(sp_q, 2) + 16'h0001))
      else $error("stack to index transfer wrong");
   wait_entry_a: assert property (@(posedge clock) disable iff (reset) // [RQ6]
      (fetch_go && op_byte == OPC_WAIT) |=> (state_q == ST_WAITING && !ccr_q[CCR_I]))
      else $error("wait did not clear mask");
   wait_hold_a: assert property (@(posedge clock) disable iff (reset) // [RQ7]
      (state_q == ST_WAITING && !irq_any) |=> $stable(pc_q) && $stable(sp_q)
      && !mem_read && !mem_write)
      else $error("core ran while waiting");
   post_inc_a: assert property (@(posedge clock) disable iff (reset) // [RQ10]
      (state_q == ST_READ && op_q == OP_MOV) |=> hx_q == $past(hx_q) + 16'h0001)
      else $error("index not incremented");
   sp_short_a: assert property (@(posedge clock) disable iff (reset) // [RQ12]
      (state_q == ST_ADR1 && mode_q == M_SP1) |=>
      ea_q == $past(sp_q) + {8'h00, $past(mem_rdata)})
      else $error("stack short address wrong");
   imd_write_a: assert property (@(posedge clock) disable iff (reset) // [RQ11]
      (state_q == ST_ADR2 && mode_q == M_IMD) |=> (mem_write && mem_wdata == $past(b1_q)
      && mem_addr == {8'h00, $past(mem_rdata)}))
      else $error("immediate move write wrong");
endmodule // cswi_core
`default_nettype wire

// >>> test_cpu_swi_transfer_test_wait_exec.sv
// self-checking bench for the trap, transfer, zero compare and wait slice
`timescale 1ns/1ps
`default_nettype none
module test_cpu_swi_transfer_test_wait_exec;
   import cswi_pkg::*;
   logic clock, reset, avs_read, avs_write, avs_waitrequest, mem_read, mem_write, irq;
   logic [4:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [7:0] mem [0:65535];
   int t_at [0:65535];
   int cyc, n_acc, num_errors, n_checks;

   cswi_core cswi_core_inst (.clock(clock), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_read(mem_read),
      .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq(irq));

   // memory answers in the same cycle, as the core has no wait states
   assign mem_rdata = mem[mem_addr];

   // clock, 10 ns period
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // memory writes land at the edge; the cycle of the latest read is logged per address
   always @(posedge clock) begin
      cyc++;
      if (mem_read === 1'b1) t_at[mem_addr] = cyc;
      if (mem_write === 1'b1) mem[mem_addr] <= mem_wdata;
      if (mem_read === 1'b1 || mem_write === 1'b1) n_acc++;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // one avalon transfer; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int i;
      @(posedge clock);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i == 20) begin
         num_errors++;
         give_verdict();
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd_check(input string name, input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(name, rd, exp);
   endtask

   // poll the status word until the core sits in the wait state
   task automatic wait_parked();
      int i;
      for (i = 0; i < 100; i++) begin
         bus(1'b0, REG_STATUS, 32'h0000_0000);
         if (rd[STATUS_WAITING] === 1'b1) break;
      end
      if (i == 100) begin
         num_errors++;
         give_verdict();
      end
   endtask

   // program: moves, loads, transfers, zero compare, wait; trap at 0200, modes at 0300
   task automatic load_program();
      logic [7:0] prog [17] = '{8'h6E, 8'hE0, 8'h40, 8'hB6, 8'h40, 8'h97, 8'h5E, 8'h40,
         8'h7E, 8'h50, 8'h94, 8'h95, 8'h84, 8'h3D, 8'h40, 8'h85, 8'h8F};
      logic [7:0] park [22] = '{8'h9E, 8'h6D, 8'h02, 8'hC6, 8'h00, 8'h40, 8'hE6, 8'h1E,
         8'hD6, 8'hFF, 8'h6E, 8'h9E, 8'hD6, 8'h00, 8'h03, 8'h01, 8'hD8, 8'h02,
         8'h9D, 8'h9D, 8'h85, 8'h8F};
      for (int i = 0; i < 65536; i++) mem[i] = 8'h9D;
      foreach (prog[i]) mem[16'h0100 + i] = prog[i];
      mem[16'h00E1] = 8'h5A;
      mem[16'hFFFA] = 8'h02;
      mem[16'hFFFB] = 8'h00;
      mem[16'hFFFC] = 8'h03;
      mem[16'hFFFD] = 8'h00;
      mem[16'h0200] = 8'h83;
      foreach (park[i]) mem[16'h0300 + i] = park[i];
   endtask

   // state after reset, core halted, unmapped read gives zero
   task automatic test_reset_state();
      rd_check("pc", REG_PC, 32'h0000_0100);
      rd_check("stack_index", REG_STACK_INDEX, 32'h0000_00FF);
      rd_check("acc_flags", REG_ACC_FLAGS, 32'h0000_6800);
      rd_check("unmapped", 5'h14, 32'h0000_0000);
      check("idle_accesses", n_acc, 0);
   endtask

   // run the first program up to its wait and judge every effect
   task automatic test_first_run();
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      wait_parked();
      check("imd_dest", mem[16'h0040], 8'hE0);
      check("dixp_dest", mem[16'h00E0], 8'hE0);
      check("ixpd_dest", mem[16'h0050], 8'h5A);
      rd_check("hx_sp", REG_STACK_INDEX, 32'h00E2_00E1);
      rd_check("flags_acc", REG_ACC_FLAGS, 32'h0000_6464);
      rd_check("pc_wait", REG_PC, 32'h0000_0111);
      check("txs_cycles", t_at[16'h010B] - t_at[16'h010A], 2);
      check("tsx_cycles", t_at[16'h010C] - t_at[16'h010B], 2);
      check("tpa_cycles", t_at[16'h0110] - t_at[16'h010F], 1);
      check("wait_no_fetch", t_at[16'h0111], 0);
   endtask

   // while parked the core touches no memory and holds its state
   task automatic test_parked();
      int k;
      k = n_acc;
      repeat (30) @(posedge clock);
      check("parked_accesses", n_acc, k);
      rd_check("pc_parked", REG_PC, 32'h0000_0111);
   endtask

   // interrupt wakes the core, vector code runs the trap, then parks again
   task automatic test_wake_and_trap();
      logic [7:0] stk [10] = '{8'h11, 8'h01, 8'hE2, 8'h64, 8'h64,
         8'h01, 8'h02, 8'hE2, 8'h64, 8'h6C};
      @(posedge clock);
      irq <= 1'b1;
      repeat (3) @(posedge clock);
      irq <= 1'b0;
      wait_parked();
      foreach (stk[i]) check("stacked", mem[16'h00E1 - i], stk[i]);
      check("trap_cycles", t_at[16'h0300] - t_at[16'h0200], 9);
      // each operand is read at its formed address in the cycle after its last byte
      check("sp1_addr", t_at[16'h00D9] - t_at[16'h0300], 3);
      check("ext_addr", t_at[16'h0040] - t_at[16'h0303], 3);
      check("ix1_addr", t_at[16'h0100] - t_at[16'h0306], 2);
      check("ix2_addr", t_at[16'h0050] - t_at[16'h0308], 3);
      check("sp2_addr", t_at[16'h00DA] - t_at[16'h030B], 4);
      check("branch_taken", t_at[16'h0314] - t_at[16'h030F], 4);
      check("branch_skip", t_at[16'h0312], 0);
      rd_check("sp_after", REG_STACK_INDEX, 32'h00E2_00D7);
      rd_check("flags_after", REG_ACC_FLAGS, 32'h0000_646C);
      rd_check("pc_after", REG_PC, 32'h0000_0316);
      rd_check("ctrl_after", REG_CTRL, 32'h0000_0001);
   endtask

   // main sequence
   initial begin
      cyc = 0;
      n_acc = 0;
      num_errors = 0;
      n_checks = 0;
      reset = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      irq = 1'b0;
      load_program();
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      test_reset_state();
      test_first_run();
      test_parked();
      test_wake_and_trap();
      give_verdict();
   end

   // watchdog so a hung core still reaches the verdict
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      give_verdict();
   end
endmodule // test_cpu_swi_transfer_test_wait_exec
`default_nettype wire
